// *** rtl/payload_ctrl_pkg.sv ***
package payload_ctrl_pkg;

	// ************************************************************
	// Register indices; the byte address is four times the index.
	// ************************************************************
	localparam logic [7:0] IDX_FRAMER_SELECT = 8'h0C;
	localparam logic [7:0] IDX_RX_ENABLE = 8'h5C;
	localparam logic [7:0] IDX_RX_STATUS = 8'h5D;
	localparam logic [7:0] IDX_TX_ENABLE = 8'h60;
	localparam logic [7:0] IDX_TX_STATUS = 8'h61;
	localparam logic [7:0] IDX_SIG_ENABLE = 8'h64;
	localparam logic [7:0] IDX_SIG_STATUS = 8'h65;
	localparam logic [7:0] IDX_PAT_INT = 8'h71;
	localparam logic [7:0] IDX_ERR_INSERT = 8'h74;
	localparam logic [7:0] IDX_ERR_COUNT_0 = 8'h7C;
	localparam logic [7:0] IDX_ERR_COUNT_1 = 8'h7D;
	localparam logic [7:0] IDX_ERR_COUNT_2 = 8'h7E;
	localparam logic [7:0] IDX_ERR_COUNT_3 = 8'h7F;
	localparam logic [7:0] IDX_RX_CFG = 8'hDC;
	localparam logic [7:0] IDX_RX_ADDR = 8'hDE;
	localparam logic [7:0] IDX_RX_DATA = 8'hDF;
	localparam logic [7:0] IDX_TX_CFG = 8'hE0;
	localparam logic [7:0] IDX_TX_ADDR = 8'hE2;
	localparam logic [7:0] IDX_TX_DATA = 8'hE3;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hF0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hF1;

	// ************************************************************
	// Field positions, reset values and counts.
	// ************************************************************
	localparam int BLOCK_ENABLE_BIT = 0;
	localparam int BUSY_BIT = 7;
	localparam int SYNC_BIT = 4;
	localparam int BEI_BIT = 2;
	localparam int ROUTE_BIT = 2;
	localparam int ERR_INSERT_BIT = 3;
	localparam int TX_TEST_BIT = 3;
	localparam int RX_TEST_BIT = 7;
	localparam int IND_READ_BIT = 7;
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_RX_DONE = 1;
	localparam int IRQ_SYNC_GAIN = 2;
	localparam int IRQ_BIT_ERROR = 3;
	localparam logic [7:0] PAT_STATUS_MASK = 8'h14;
	localparam logic [6:0] TS_BASE = 7'h20;
	localparam int NUM_TS = 32;
	localparam int IND_DEPTH = 128;
	localparam logic [2:0] IND_CYCLES = 3'h4;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {IND_IDLE, IND_BUSY} ind_state_e;

	typedef struct packed {
		ind_state_e state;
		logic [2:0] cnt;
		logic [7:0] addr;
		logic [7:0] data;
	} ind_chan_s;

	typedef struct packed {
		logic sync;
		logic bit_error;
		logic [31:0] err_count;
	} detector_stat_s;

	typedef struct packed {
		logic [31:0] tx_test;
		logic [31:0] rx_test;
		logic backplane_route;
		logic err_insert;
	} test_ctrl_s;

endpackage

// *** rtl/payload_control_indirect_access.sv ***
// Function
// [R1] Host writes tx data byte, then tx address.
// [R2] Tx location value 08H sets timeslot test flag.
// [R3] Host writes rx data byte, then rx address.
// [R4] Rx location value 80H sets timeslot test flag.
// [R5] Host clears every indirect location before use.
// [R6] Rx space 20H-3FH cleared with 00H.
// [R7] Tx space up to 7FH cleared with 00H.
// [R8] Each block works only when bit0 set.
// [R9] Busy flag in status bit 7; host waits.
// [R10] Sync bit4 one, bit-error bit2 zero means synchronized.
// [R11] Host reads detector status register twice.
// [R12] Writing 08H then 00H inserts one error.
// [R13] Writing count register zero latches error count.
// [R14] Latched count read over four byte registers.
// [R15] Route bit sends pattern over backplane path.
// [R16] Address write starts transfer; busy until done.
// [R17] Indirect read data lands when busy clears.
// [R18] Config value 01H opens indirect access.
`timescale 1ns/1ps
`default_nettype none

module payload_control_indirect_access #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire payload_ctrl_pkg::detector_stat_s det_stat,
	output payload_ctrl_pkg::test_ctrl_s test_ctrl,
	output logic irq
);

	// ************************************************************
	// Address decode and indirect channel step.
	// ************************************************************
	function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		idx_mapped = 1'b0;
		if (a[ADDR_W-1:10] == '0 && a[1:0] == 2'h0) begin
			case (i)
				payload_ctrl_pkg::IDX_FRAMER_SELECT, payload_ctrl_pkg::IDX_RX_ENABLE,
				payload_ctrl_pkg::IDX_RX_STATUS, payload_ctrl_pkg::IDX_TX_ENABLE,
				payload_ctrl_pkg::IDX_TX_STATUS, payload_ctrl_pkg::IDX_SIG_ENABLE,
				payload_ctrl_pkg::IDX_SIG_STATUS, payload_ctrl_pkg::IDX_PAT_INT,
				payload_ctrl_pkg::IDX_ERR_INSERT, payload_ctrl_pkg::IDX_ERR_COUNT_0,
				payload_ctrl_pkg::IDX_ERR_COUNT_1, payload_ctrl_pkg::IDX_ERR_COUNT_2,
				payload_ctrl_pkg::IDX_ERR_COUNT_3, payload_ctrl_pkg::IDX_RX_CFG,
				payload_ctrl_pkg::IDX_RX_ADDR, payload_ctrl_pkg::IDX_RX_DATA,
				payload_ctrl_pkg::IDX_TX_CFG, payload_ctrl_pkg::IDX_TX_ADDR,
				payload_ctrl_pkg::IDX_TX_DATA, payload_ctrl_pkg::IDX_IRQ_STATUS,
				payload_ctrl_pkg::IDX_IRQ_MASK: begin
					idx_mapped = 1'b1;
				end
				default: begin
					idx_mapped = 1'b0;
				end
			endcase
		end
	endfunction

	// Writes to the data or address register while busy are dropped, so a
	// transfer in flight can never be corrupted by an impatient host.
	function automatic payload_ctrl_pkg::ind_chan_s ind_step(
		input payload_ctrl_pkg::ind_chan_s c,
		input logic go,
		input logic addr_wr,
		input logic data_wr,
		input logic [7:0] wd,
		input logic [7:0] mem_rd
	);
		payload_ctrl_pkg::ind_chan_s n;
		n = c;
		case (c.state)
			payload_ctrl_pkg::IND_IDLE: begin
				if (data_wr) begin
					n.data = wd;
				end
				if (addr_wr) begin
					n.addr = wd;
					if (go) begin
						n.state = payload_ctrl_pkg::IND_BUSY; // [R16]
						n.cnt = payload_ctrl_pkg::IND_CYCLES - 3'h1;
					end
				end
			end
			payload_ctrl_pkg::IND_BUSY: begin
				if (c.cnt == 3'h0) begin
					n.state = payload_ctrl_pkg::IND_IDLE;
					if (c.addr[payload_ctrl_pkg::IND_READ_BIT]) begin
						n.data = mem_rd; // [R17]
					end
				end else begin
					n.cnt = c.cnt - 3'h1;
				end
			end
			default: begin
				n.state = payload_ctrl_pkg::IND_IDLE;
			end
		endcase
		return n;
	endfunction

	// ************************************************************
	// State.
	// ************************************************************
	logic [7:0] tx_mem [payload_ctrl_pkg::IND_DEPTH];
	logic [7:0] rx_mem [payload_ctrl_pkg::IND_DEPTH];
	payload_ctrl_pkg::ind_chan_s tx_reg, tx_next, rx_reg, rx_next;
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [7:0] rbyte_reg, rbyte_next;
	logic [7:0] framer_sel_reg, framer_sel_next, rx_en_reg, rx_en_next, tx_en_reg, tx_en_next;
	logic [7:0] sig_en_reg, sig_en_next, rx_cfg_reg, rx_cfg_next, tx_cfg_reg, tx_cfg_next;
	logic [7:0] pat_int_reg, pat_int_next, err_ins_reg, err_ins_next;
	logic [7:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
	logic [31:0] count_reg, count_next;
	logic sync_q_reg, sync_q_next, bei_q_reg, bei_q_next;
	payload_ctrl_pkg::test_ctrl_s test_reg, test_next;
	logic irq_reg, irq_next;
	logic wr_do, wr_en, tx_done, rx_done, tx_mem_we, rx_mem_we;
	logic [7:0] widx, ridx, events;

	assign awready = !aw_hold_reg;
	assign wready = !w_hold_reg;
	assign arready = !rvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = {24'h000000, rbyte_reg};
	assign test_ctrl = test_reg;
	assign irq = irq_reg;

	// ************************************************************
	// Next-state logic.
	// ************************************************************
	always_comb begin
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		w_hold_next = w_hold_reg;
		wbyte_next = wbyte_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rbyte_next = rbyte_reg;
		framer_sel_next = framer_sel_reg;
		rx_en_next = rx_en_reg;
		tx_en_next = tx_en_reg;
		sig_en_next = sig_en_reg;
		rx_cfg_next = rx_cfg_reg;
		tx_cfg_next = tx_cfg_reg;
		pat_int_next = pat_int_reg;
		err_ins_next = err_ins_reg;
		irq_mask_next = irq_mask_reg;
		count_next = count_reg;
		test_next = test_reg;
		test_next.err_insert = 1'b0;
		sync_q_next = det_stat.sync;
		bei_q_next = det_stat.bit_error;

		if (awvalid && awready) begin
			aw_hold_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && wready) begin
			w_hold_next = 1'b1;
			wbyte_next = wdata[7:0];
			wstrb0_next = wstrb[0];
		end
		if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
		widx = aw_addr_reg[9:2];
		wr_en = wr_do && wstrb0_reg && idx_mapped(aw_addr_reg);
		if (wr_do) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = idx_mapped(aw_addr_reg) ? payload_ctrl_pkg::RESP_OKAY : payload_ctrl_pkg::RESP_SLVERR;
		end

		if (wr_en) begin
			case (widx)
				payload_ctrl_pkg::IDX_FRAMER_SELECT: begin
					framer_sel_next = wbyte_reg;
				end
				payload_ctrl_pkg::IDX_RX_ENABLE: begin
					rx_en_next = wbyte_reg;
				end
				payload_ctrl_pkg::IDX_TX_ENABLE: begin
					tx_en_next = wbyte_reg;
				end
				payload_ctrl_pkg::IDX_SIG_ENABLE: begin
					sig_en_next = wbyte_reg;
				end
				payload_ctrl_pkg::IDX_RX_CFG: begin
					rx_cfg_next = wbyte_reg;
				end
				payload_ctrl_pkg::IDX_TX_CFG: begin
					tx_cfg_next = wbyte_reg;
				end
				payload_ctrl_pkg::IDX_PAT_INT: begin
					pat_int_next = wbyte_reg & ~payload_ctrl_pkg::PAT_STATUS_MASK;
				end
				payload_ctrl_pkg::IDX_ERR_INSERT: begin
					err_ins_next = wbyte_reg;
					// Only a 0-to-1 step of the bit inserts, so 08H must be followed by 00H.
					test_next.err_insert = wbyte_reg[payload_ctrl_pkg::ERR_INSERT_BIT] &&
						!err_ins_reg[payload_ctrl_pkg::ERR_INSERT_BIT]; // [R12]
				end
				payload_ctrl_pkg::IDX_ERR_COUNT_0: begin
					count_next = det_stat.err_count; // [R13]
				end
				payload_ctrl_pkg::IDX_IRQ_MASK: begin
					irq_mask_next = wbyte_reg;
				end
				default: begin
				end
			endcase
		end

		// Indirect channels; the access enable and the block enable must both be set.
		tx_next = ind_step(tx_reg, tx_cfg_reg[payload_ctrl_pkg::BLOCK_ENABLE_BIT] &&
			tx_en_reg[payload_ctrl_pkg::BLOCK_ENABLE_BIT], // [R18] [R8]
			wr_en && widx == payload_ctrl_pkg::IDX_TX_ADDR,
			wr_en && widx == payload_ctrl_pkg::IDX_TX_DATA, wbyte_reg,
			tx_mem[tx_reg.addr[6:0]]); // [R1]
		rx_next = ind_step(rx_reg, rx_cfg_reg[payload_ctrl_pkg::BLOCK_ENABLE_BIT] &&
			rx_en_reg[payload_ctrl_pkg::BLOCK_ENABLE_BIT], // [R18] [R8]
			wr_en && widx == payload_ctrl_pkg::IDX_RX_ADDR,
			wr_en && widx == payload_ctrl_pkg::IDX_RX_DATA, wbyte_reg,
			rx_mem[rx_reg.addr[6:0]]); // [R3]
		tx_done = tx_reg.state == payload_ctrl_pkg::IND_BUSY && tx_reg.cnt == 3'h0;
		rx_done = rx_reg.state == payload_ctrl_pkg::IND_BUSY && rx_reg.cnt == 3'h0;
		tx_mem_we = tx_done && !tx_reg.addr[payload_ctrl_pkg::IND_READ_BIT]; // [R7]
		rx_mem_we = rx_done && !rx_reg.addr[payload_ctrl_pkg::IND_READ_BIT]; // [R6]

		for (int t = 0; t < payload_ctrl_pkg::NUM_TS; t++) begin
			test_next.tx_test[t] = tx_en_reg[payload_ctrl_pkg::BLOCK_ENABLE_BIT] &&
				tx_mem[payload_ctrl_pkg::TS_BASE + 7'(t)][payload_ctrl_pkg::TX_TEST_BIT]; // [R2] [R8]
			test_next.rx_test[t] = rx_en_reg[payload_ctrl_pkg::BLOCK_ENABLE_BIT] &&
				rx_mem[payload_ctrl_pkg::TS_BASE + 7'(t)][payload_ctrl_pkg::RX_TEST_BIT]; // [R4] [R8]
		end
		test_next.backplane_route = framer_sel_reg[payload_ctrl_pkg::ROUTE_BIT]; // [R15]

		// Interrupts: a new event beats a clear in the same cycle.
		events = 8'h00;
		events[payload_ctrl_pkg::IRQ_TX_DONE] = tx_done;
		events[payload_ctrl_pkg::IRQ_RX_DONE] = rx_done;
		events[payload_ctrl_pkg::IRQ_SYNC_GAIN] = det_stat.sync && !sync_q_reg;
		events[payload_ctrl_pkg::IRQ_BIT_ERROR] = det_stat.bit_error && !bei_q_reg;
		irq_stat_next = irq_stat_reg;
		if (wr_en && widx == payload_ctrl_pkg::IDX_IRQ_STATUS) begin
			irq_stat_next = irq_stat_next & ~wbyte_reg;
		end
		irq_stat_next = irq_stat_next | events;
		irq_next = |(irq_stat_next & irq_mask_next);

		if (rready && rvalid_reg) begin
			rvalid_next = 1'b0;
		end
		ridx = araddr[9:2];
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rresp_next = idx_mapped(araddr) ? payload_ctrl_pkg::RESP_OKAY : payload_ctrl_pkg::RESP_SLVERR;
			case (idx_mapped(araddr) ? ridx : 8'h00)
				payload_ctrl_pkg::IDX_FRAMER_SELECT: rbyte_next = framer_sel_reg;
				payload_ctrl_pkg::IDX_RX_ENABLE: rbyte_next = rx_en_reg;
				payload_ctrl_pkg::IDX_TX_ENABLE: rbyte_next = tx_en_reg;
				payload_ctrl_pkg::IDX_SIG_ENABLE: rbyte_next = sig_en_reg;
				payload_ctrl_pkg::IDX_RX_STATUS: rbyte_next = {rx_reg.state == payload_ctrl_pkg::IND_BUSY, 7'h00}; // [R9]
				payload_ctrl_pkg::IDX_TX_STATUS: rbyte_next = {tx_reg.state == payload_ctrl_pkg::IND_BUSY, 7'h00}; // [R9]
				payload_ctrl_pkg::IDX_SIG_STATUS: rbyte_next = 8'h00;
				payload_ctrl_pkg::IDX_PAT_INT: rbyte_next = pat_int_reg | {3'h0, sync_q_reg, 1'b0, bei_q_reg, 2'h0}; // [R10]
				payload_ctrl_pkg::IDX_ERR_INSERT: rbyte_next = err_ins_reg;
				payload_ctrl_pkg::IDX_ERR_COUNT_0: rbyte_next = count_reg[7:0]; // [R14]
				payload_ctrl_pkg::IDX_ERR_COUNT_1: rbyte_next = count_reg[15:8]; // [R14]
				payload_ctrl_pkg::IDX_ERR_COUNT_2: rbyte_next = count_reg[23:16]; // [R14]
				payload_ctrl_pkg::IDX_ERR_COUNT_3: rbyte_next = count_reg[31:24]; // [R14]
				payload_ctrl_pkg::IDX_RX_CFG: rbyte_next = rx_cfg_reg;
				payload_ctrl_pkg::IDX_TX_CFG: rbyte_next = tx_cfg_reg;
				payload_ctrl_pkg::IDX_RX_ADDR: rbyte_next = rx_reg.addr;
				payload_ctrl_pkg::IDX_RX_DATA: rbyte_next = rx_reg.data;
				payload_ctrl_pkg::IDX_TX_ADDR: rbyte_next = tx_reg.addr;
				payload_ctrl_pkg::IDX_TX_DATA: rbyte_next = tx_reg.data;
				payload_ctrl_pkg::IDX_IRQ_STATUS: rbyte_next = irq_stat_reg;
				payload_ctrl_pkg::IDX_IRQ_MASK: rbyte_next = irq_mask_reg;
				default: rbyte_next = 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Registers.
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_hold_reg <= 1'b0;
			wbyte_reg <= payload_ctrl_pkg::BYTE_RESET;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= payload_ctrl_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= payload_ctrl_pkg::RESP_OKAY;
			rbyte_reg <= payload_ctrl_pkg::BYTE_RESET;
			framer_sel_reg <= payload_ctrl_pkg::BYTE_RESET;
			rx_en_reg <= payload_ctrl_pkg::BYTE_RESET;
			tx_en_reg <= payload_ctrl_pkg::BYTE_RESET;
			sig_en_reg <= payload_ctrl_pkg::BYTE_RESET;
			rx_cfg_reg <= payload_ctrl_pkg::BYTE_RESET;
			tx_cfg_reg <= payload_ctrl_pkg::BYTE_RESET;
			pat_int_reg <= payload_ctrl_pkg::BYTE_RESET;
			err_ins_reg <= payload_ctrl_pkg::BYTE_RESET;
			irq_stat_reg <= payload_ctrl_pkg::BYTE_RESET;
			irq_mask_reg <= payload_ctrl_pkg::BYTE_RESET;
			count_reg <= 32'h00000000;
			sync_q_reg <= 1'b0;
			bei_q_reg <= 1'b0;
			test_reg <= '0;
			irq_reg <= 1'b0;
			tx_reg <= '{payload_ctrl_pkg::IND_IDLE, 3'h0, 8'h00, 8'h00};
			rx_reg <= '{payload_ctrl_pkg::IND_IDLE, 3'h0, 8'h00, 8'h00};
		end else begin
			aw_hold_reg <= aw_hold_next;
			aw_addr_reg <= aw_addr_next;
			w_hold_reg <= w_hold_next;
			wbyte_reg <= wbyte_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rbyte_reg <= rbyte_next;
			framer_sel_reg <= framer_sel_next;
			rx_en_reg <= rx_en_next;
			tx_en_reg <= tx_en_next;
			sig_en_reg <= sig_en_next;
			rx_cfg_reg <= rx_cfg_next;
			tx_cfg_reg <= tx_cfg_next;
			pat_int_reg <= pat_int_next;
			err_ins_reg <= err_ins_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			count_reg <= count_next;
			sync_q_reg <= sync_q_next;
			bei_q_reg <= bei_q_next;
			test_reg <= test_next;
			irq_reg <= irq_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
		end
	end

	// Reset clears the tables too, so no timeslot tests before software runs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < payload_ctrl_pkg::IND_DEPTH; i++) begin
				tx_mem[i] <= payload_ctrl_pkg::BYTE_RESET;
				rx_mem[i] <= payload_ctrl_pkg::BYTE_RESET;
			end
		end else begin
			if (tx_mem_we) begin
				tx_mem[tx_reg.addr[6:0]] <= tx_reg.data;
			end
			if (rx_mem_we) begin
				rx_mem[rx_reg.addr[6:0]] <= rx_reg.data;
			end
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	chk_tx_busy_len: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
		$rose(tx_reg.state == payload_ctrl_pkg::IND_BUSY) |->
		(tx_reg.state == payload_ctrl_pkg::IND_BUSY) [*4] ##1 (tx_reg.state == payload_ctrl_pkg::IND_IDLE))
		else $error("tx indirect busy length wrong");
	chk_rx_busy_len: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
		$rose(rx_reg.state == payload_ctrl_pkg::IND_BUSY) |->
		(rx_reg.state == payload_ctrl_pkg::IND_BUSY) [*4] ##1 (rx_reg.state == payload_ctrl_pkg::IND_IDLE))
		else $error("rx indirect busy length wrong");
	chk_tx_test_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		(tx_mem_we && tx_reg.addr == 8'h22 && tx_reg.data == 8'h08 && tx_en_reg[0] && tx_en_next[0])
		|-> ##2 test_reg.tx_test[2])
		else $error("tx timeslot test flag not set");
	chk_rx_test_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		(rx_mem_we && rx_reg.addr == 8'h22 && rx_reg.data == 8'h80 && rx_en_reg[0] && rx_en_next[0])
		|-> ##2 test_reg.rx_test[2])
		else $error("rx timeslot test flag not set");
	chk_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
		(!tx_en_reg[0] |=> test_reg.tx_test == 32'h00000000) and (!rx_en_reg[0] |=> test_reg.rx_test == 32'h00000000))
		else $error("disabled block drives test flags");
	chk_err_once: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
		test_reg.err_insert |=> !test_reg.err_insert ##1 !test_reg.err_insert)
		else $error("error insert pulse too long");
	chk_count_latch: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
		wr_en && widx == payload_ctrl_pkg::IDX_ERR_COUNT_0 |=> count_reg == $past(det_stat.err_count))
		else $error("error count not latched");
	chk_route_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
		wr_en && widx == payload_ctrl_pkg::IDX_FRAMER_SELECT |-> ##2 test_reg.backplane_route == $past(wbyte_reg[2], 2))
		else $error("backplane route not applied");
	chk_sync_view: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		arvalid && arready && araddr == ADDR_W'({payload_ctrl_pkg::IDX_PAT_INT, 2'h0})
		|=> rdata[4] == $past(sync_q_reg) && rdata[2] == $past(bei_q_reg))
		else $error("detector status bits misplaced");

endmodule

`default_nettype wire

// *** test/pattern_detector_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Detector stand-in
// ****
// Counts each inserted error on top of a fixed base, so all four count bytes carry data.
module pattern_detector_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire payload_ctrl_pkg::test_ctrl_s tc,
	input wire logic sync_in,
	input wire logic [31:0] base,
	output payload_ctrl_pkg::detector_stat_s ds
);
	logic sync_reg, err_reg;
	logic [31:0] cnt_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{sync_reg, err_reg, cnt_reg} <= '0;
		end else begin
			sync_reg <= sync_in;
			err_reg <= tc.err_insert;
			cnt_reg <= cnt_reg + 32'(tc.err_insert);
		end
	end
	assign ds = '{sync_reg, err_reg, base + cnt_reg};
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sync_in = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rsp;
	payload_ctrl_pkg::detector_stat_s det_stat;
	payload_ctrl_pkg::test_ctrl_s test_ctrl;
	int n_mismatch = 0, n_tests = 0, cyc = 0, seed = 40;
	logic [7:0] tbl [2][128] = '{default: 8'h00};
	logic ena [2] = '{1'b0, 1'b0};
	localparam logic [31:0] ERR_BASE = 32'hA1B2C3D4;
	always #2.5 aclk = ~aclk;
	// Responses are always accepted at once, so no handshake can stall on the bench side.
	payload_control_indirect_access u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(1'b1), .det_stat(det_stat), .test_ctrl(test_ctrl), .irq(irq));
	pattern_detector_model u_det (.aclk(aclk), .aresetn(aresetn), .tc(test_ctrl), .sync_in(sync_in),
		.base(ERR_BASE), .ds(det_stat));
	// ****
	// Bus tasks and model
	// ****
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
	endtask
	task automatic rd_reg(input logic [7:0] idx);
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rsp = rresp;
	endtask
	task automatic wait_idle(input bit rx);
		do rd_reg(rx ? payload_ctrl_pkg::IDX_RX_STATUS : payload_ctrl_pkg::IDX_TX_STATUS);
		while (rd[payload_ctrl_pkg::BUSY_BIT]);
	endtask
	task automatic ind_wr(input bit rx, input int loc, input logic [7:0] d);
		wait_idle(rx);
		wr(rx ? payload_ctrl_pkg::IDX_RX_DATA : payload_ctrl_pkg::IDX_TX_DATA, d);
		wr(rx ? payload_ctrl_pkg::IDX_RX_ADDR : payload_ctrl_pkg::IDX_TX_ADDR, 8'(loc));
		if (ena[rx]) tbl[rx][loc] = d;
		rd_reg(rx ? payload_ctrl_pkg::IDX_RX_STATUS : payload_ctrl_pkg::IDX_TX_STATUS);
		chk("busy flag", {24'h0, ena[rx], 7'h00}, rd & 32'h80);
		wait_idle(rx);
	endtask
	task automatic ind_rd(input bit rx, input int loc);
		wait_idle(rx);
		// A marker in the data register shows whether the read really reloads it.
		wr(rx ? payload_ctrl_pkg::IDX_RX_DATA : payload_ctrl_pkg::IDX_TX_DATA, 8'h5A);
		wr(rx ? payload_ctrl_pkg::IDX_RX_ADDR : payload_ctrl_pkg::IDX_TX_ADDR, 8'(loc) | 8'h80);
		wait_idle(rx);
		rd_reg(rx ? payload_ctrl_pkg::IDX_RX_DATA : payload_ctrl_pkg::IDX_TX_DATA);
	endtask
	function automatic logic [31:0] flags(input bit rx);
		logic [31:0] v;
		for (int t = 0; t < 32; t++) v[t] = ena[rx] & tbl[rx][32 + t][rx ? 7 : 3];
		return v;
	endfunction
	task automatic chk_flags();
		repeat (3) @(posedge aclk);
		chk("tx_test", flags(0), test_ctrl.tx_test);
		chk("rx_test", flags(1), test_ctrl.rx_test);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(payload_ctrl_pkg::IDX_TX_ENABLE);
		chk("tx_enable reset", 32'h0, rd);
		rd_reg(8'h01);
		chk("unmapped rresp", 32'(payload_ctrl_pkg::RESP_SLVERR), 32'(rsp));
		wr(8'h01, 8'h00);
		chk("unmapped bresp", 32'(payload_ctrl_pkg::RESP_SLVERR), 32'(rsp));
		wr(payload_ctrl_pkg::IDX_TX_CFG, 8'h01);
		chk("mapped bresp", 32'(payload_ctrl_pkg::RESP_OKAY), 32'(rsp));
		wr(payload_ctrl_pkg::IDX_RX_CFG, 8'h01);
		wr(payload_ctrl_pkg::IDX_TX_ENABLE, 8'h01);
		wr(payload_ctrl_pkg::IDX_RX_ENABLE, 8'h01);
		ena = '{1'b1, 1'b1};
		// Stale random contents first, so that clearing has something to remove.
		for (int l = 32; l < 128; l++) ind_wr(0, l, 8'($random(seed)));
		for (int l = 32; l < 64; l++) ind_wr(1, l, 8'($random(seed)));
		chk_flags();
		for (int l = 32; l < 128; l++) ind_wr(0, l, 8'h00);
		for (int l = 32; l < 64; l++) ind_wr(1, l, 8'h00);
		ind_rd(0, 127);
		chk("tx loc 7F", 32'h0, rd);
		chk_flags();
		for (int i = 34; i < 38; i++) if (i != 35) begin
			ind_wr(0, i, 8'h08);
			ind_wr(1, i, 8'h80);
		end
		chk_flags();
		ind_rd(1, 36);
		chk("rx loc 24", 32'h80, rd);
		wr(payload_ctrl_pkg::IDX_TX_ENABLE, 8'h00);
		ena[0] = 1'b0;
		ind_wr(0, 34, 8'h00);
		chk_flags();
		wr(payload_ctrl_pkg::IDX_TX_ENABLE, 8'h01);
		ena[0] = 1'b1;
		chk_flags();
		wr(payload_ctrl_pkg::IDX_FRAMER_SELECT, 8'h04);
		repeat (2) @(posedge aclk);
		chk("route", 32'h1, 32'(test_ctrl.backplane_route));
		sync_in <= 1'b1;
		repeat (3) @(posedge aclk);
		rd_reg(payload_ctrl_pkg::IDX_PAT_INT);
		rd_reg(payload_ctrl_pkg::IDX_PAT_INT);
		chk("sync status", 32'h10, rd & 32'(payload_ctrl_pkg::PAT_STATUS_MASK));
		repeat (3) begin
			wr(payload_ctrl_pkg::IDX_ERR_INSERT, 8'h08);
			wr(payload_ctrl_pkg::IDX_ERR_INSERT, 8'h00);
		end
		wr(payload_ctrl_pkg::IDX_ERR_COUNT_0, 8'h00);
		wr(payload_ctrl_pkg::IDX_ERR_INSERT, 8'h08);
		wr(payload_ctrl_pkg::IDX_ERR_INSERT, 8'h00);
		for (int k = 0; k < 4; k++) begin
			rd_reg(payload_ctrl_pkg::IDX_ERR_COUNT_0 + 8'(k));
			chk("err count byte", 32'(8'((ERR_BASE + 32'h3) >> (8 * k))), rd);
		end
		wr(payload_ctrl_pkg::IDX_IRQ_STATUS, 8'hFF);
		ind_wr(0, 64, 8'h00);
		chk("irq masked", 32'h0, 32'(irq));
		wr(payload_ctrl_pkg::IDX_IRQ_MASK, 8'h01);
		repeat (2) @(posedge aclk);
		chk("irq raised", 32'h1, 32'(irq));
		wr(payload_ctrl_pkg::IDX_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, 32'(irq));
		print_verdict();
	end
endmodule
`default_nettype wire
